// file: dci_core_model.sv
/*
 * Model of the two cores and the debug port: sleep levels and
 * system function requests. Assumes the router's clock.
 */
module dci_core_model (
    input wire logic clk_i,
    output logic [2:0] sysreq_o,
    output logic [1:0] sleep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sysreq_o = 3'h0;
        sleep_o = 2'h0;
    end
    // Core requests are one-cycle pulses; the debug port level is
    // asynchronous, so it stays up long enough to cross the synchroniser
    task automatic sysreq(input int who);
        sysreq_o <= 3'h1 << who;
        repeat ((who == 2) ? 8 : 1) @(posedge clk_i);
        sysreq_o <= 3'h0;
        @(posedge clk_i);
    endtask : sysreq
    task automatic sleep(input logic m, input logic s);
        sleep_o <= {s, m};
        @(posedge clk_i);
    endtask : sleep
endmodule : dci_core_model

// file: dci_pkg.sv
/*
 * Shared constants and carrier types of the dual-core interrupt router:
 * source counts, register byte offsets, reset values and bus structs.
 * Assumes one 125 MHz clock domain and a classic Wishbone register bus.
 */
package dci_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_SRC = 175;
    localparam int unsigned SEC_LINES = 8;
    localparam int unsigned SW_INTS = 8;
    localparam int unsigned NUM_CH = 16;
    localparam int unsigned NUM_STR = 16;
    localparam int unsigned SYS_CH = 8;
    localparam int unsigned SYS_STR = 8;
    localparam int unsigned WAKE_SRC = 45;
    localparam int unsigned NMI_SLOTS = 4;
    localparam int unsigned SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] NMI_OFF = 8'hFF;
    localparam logic [2:0] SYS_LINE = 3'h7;
    localparam logic [31:0] NMI_RST = 32'hFFFF_FFFF;
    localparam logic [8:0] ENT_RST = 9'h007;
    localparam logic [15:0] SEC_PRIO_RST = 16'hFFFF;
    localparam logic CORE_MAIN = 1'b0;
    localparam logic CORE_SEC = 1'b1;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] A_ENT_SEL = 12'h000;
    localparam logic [11:0] A_ENT_DATA = 12'h004;
    localparam logic [11:0] A_NMI_MAIN = 12'h008;
    localparam logic [11:0] A_NMI_SEC = 12'h00C;
    localparam logic [11:0] A_SWINT = 12'h010;
    localparam logic [11:0] A_SYSREQ = 12'h014;
    localparam logic [11:0] A_SEC_PRIO = 12'h018;
    localparam logic [11:0] A_STATUS = 12'h01C;
    localparam logic [3:0] PAGE_CH = 4'h1;
    localparam logic [3:0] PAGE_STR = 4'h2;
    localparam logic [1:0] CH_ACQUIRE = 2'h0;
    localparam logic [1:0] CH_RELEASE = 2'h1;
    localparam logic [1:0] CH_NOTIFY = 2'h2;
    localparam logic [1:0] CH_DATA = 2'h3;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wake_en;
        logic sec_en;
        logic [2:0] line;
        logic rsvd;
        logic [2:0] prio;
    } dci_entry_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
        logic core;
    } dci_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } dci_wb_rsp_t;

endpackage : dci_pkg

// file: dci_router.sv
/*
 * Dual-core interrupt router with inter-core channels.
 * Assumes: sources and core signals are on clk_i; the debug port request
 * is asynchronous; bus requests carry the requesting core in req.core.
 */
// Function
// - Source n drives main core request line n directly, no remapping.
// - Secondary core has eight request lines fed by configurable source multiplexers.
// - Secondary core has eight software-only internal interrupts.
// - Priorities: eight levels for main core, four for secondary core.
// - Up to four sources per core routed onto that core's NMI.
// - Only sources 0 to 44 can wake the device from deep sleep.
// - Each core has a wakeup unit that wakes it from deep sleep.
// - Sixteen channels and sixteen interrupt structures for data exchange.
// - Each channel has a hardware lock held by one party at a time.
// - One core interrupts the other through structures, on notify and release.
// - Channels 0-7, structures 0-7, secondary NMI and line 7 are system-reserved; the main core can still read and write structures 0-7.
// - System function request from either core or debug port raises secondary NMI.
module dci_router
    import dci_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [dci_pkg::NUM_SRC-1:0] src_i,
    input wire dci_pkg::dci_wb_req_t wb_i,
    output dci_pkg::dci_wb_rsp_t wb_o,
    input wire logic main_sysreq_i,
    input wire logic sec_sysreq_i,
    input wire logic dap_sysreq_i,
    input wire logic main_sleep_i,
    input wire logic sec_sleep_i,
    output logic [dci_pkg::NUM_SRC-1:0] main_irq_o,
    output logic main_nmi_o,
    output logic [7:0] main_top_id_o,
    output logic [2:0] main_top_prio_o,
    output logic main_top_valid_o,
    output logic main_wake_o,
    output logic [dci_pkg::SEC_LINES-1:0] sec_irq_o,
    output logic [dci_pkg::SW_INTS-1:0] sec_swint_o,
    output logic sec_nmi_o,
    output logic [2:0] sec_top_line_o,
    output logic sec_top_valid_o,
    output logic sec_wake_o,
    output logic [dci_pkg::NUM_STR-1:0] ipc_irq_o
);
    import dci_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8+:8] = nw[b*8+:8];
        end
        return r;
    endfunction : merge

    function automatic logic nmi_hit(input logic [NUM_SRC-1:0] s, input logic [31:0] cfg);
        logic h;
        h = 1'b0;
        for (int k = 0; k < NMI_SLOTS; k++) begin
            if (cfg[k*8+:8] != NMI_OFF && cfg[k*8+:8] < 8'(NUM_SRC) && s[cfg[k*8+:8]]) h = 1'b1;
        end
        return h;
    endfunction : nmi_hit

    // Main core is kept out of the system-reserved channels
    function automatic logic ch_ok(input logic [3:0] ch, input logic core);
        return (core == CORE_SEC) || (ch >= 4'(SYS_CH));
    endfunction : ch_ok

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic ack_q;
    logic acc;
    logic wr;
    logic rd;
    logic is_ch;
    logic is_st;
    logic [3:0] ch;
    logic [1:0] creg;
    logic [3:0] st;
    logic sreg;
    logic ok;

    assign acc = wb_i.cyc & wb_i.stb & ~ack_q;
    assign wr = acc & wb_i.we;
    assign rd = acc & ~wb_i.we;
    assign is_ch = wb_i.adr[11:8] == PAGE_CH;
    assign is_st = (wb_i.adr[11:8] == PAGE_STR) && !wb_i.adr[7];
    assign ch = wb_i.adr[7:4];
    assign creg = wb_i.adr[3:2];
    assign st = wb_i.adr[6:3];
    assign sreg = wb_i.adr[2];
    assign ok = ch_ok(ch, wb_i.core);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    dci_entry_t ent_q [NUM_SRC];
    logic [7:0] ent_sel_q;
    logic [31:0] nmi_main_q;
    logic [31:0] nmi_sec_q;
    logic [15:0] sec_prio_q;
    logic [2:0] sysreq_q;
    logic [NUM_SRC-1:0] wake_en;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int n = 0; n < NUM_SRC; n++) ent_q[n] <= dci_entry_t'(ENT_RST);
        end else if (wr && wb_i.adr == A_ENT_DATA && ent_sel_q < 8'(NUM_SRC)) begin
            ent_q[ent_sel_q] <= dci_entry_t'(merge({23'h0, ent_q[ent_sel_q]}, wb_i.dat, wb_i.sel));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ent_sel_q <= 8'h00;
            nmi_main_q <= NMI_RST;
            nmi_sec_q <= NMI_RST;
            sec_prio_q <= SEC_PRIO_RST;
            sec_swint_o <= 8'h00;
        end else if (wr) begin
            unique case (wb_i.adr)
                A_ENT_SEL: if (wb_i.sel[0]) ent_sel_q <= wb_i.dat[7:0];
                A_NMI_MAIN: nmi_main_q <= merge(nmi_main_q, wb_i.dat, wb_i.sel);
                // Secondary NMI selection belongs to the system core only
                A_NMI_SEC: if (wb_i.core == CORE_SEC) nmi_sec_q <= merge(nmi_sec_q, wb_i.dat, wb_i.sel);
                A_SEC_PRIO: sec_prio_q <= 16'(merge({16'h0, sec_prio_q}, wb_i.dat, wb_i.sel));
                A_SWINT: if (wb_i.sel[0]) sec_swint_o <= wb_i.dat[7:0];
                default: ;
            endcase
        end
    end

    generate
        for (genvar n = 0; n < NUM_SRC; n++) begin : g_wake
            assign wake_en[n] = (n < WAKE_SRC) && ent_q[n].wake_en;
        end
    endgenerate

    // ----------------------------------------------------------------
    // System function requests
    // ----------------------------------------------------------------
    logic dap_lvl;
    logic dap_lvl_q;

    dci_sync u_dap_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(dap_sysreq_i),
        .level_o(dap_lvl)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dap_lvl_q <= 1'b0;
        end else begin
            dap_lvl_q <= dap_lvl;
        end
    end

    // Set wins over a same-cycle clear so no request is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysreq_q <= 3'h0;
        end else begin
            sysreq_q <= (sysreq_q & ~((wr && wb_i.adr == A_SYSREQ && wb_i.sel[0]) ? wb_i.dat[2:0] : 3'h0))
                        | {dap_lvl & ~dap_lvl_q, sec_sysreq_i, main_sysreq_i};
        end
    end

    // ----------------------------------------------------------------
    // Inter-core channels
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] lock_q;
    logic [NUM_CH-1:0] owner_q;
    logic [31:0] data_q [NUM_CH];
    logic [31:0] npend_q [NUM_STR];
    logic [31:0] mask_q [NUM_STR];
    logic do_rel;
    logic do_nfy;

    assign do_rel = wr && is_ch && creg == CH_RELEASE && ok && lock_q[ch] && owner_q[ch] == wb_i.core;
    assign do_nfy = wr && is_ch && creg == CH_NOTIFY && ok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_q <= '0;
            owner_q <= '0;
        end else if (rd && is_ch && creg == CH_ACQUIRE && ok && !lock_q[ch]) begin
            lock_q[ch] <= 1'b1;
            owner_q[ch] <= wb_i.core;
        end else if (do_rel) begin
            lock_q[ch] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) data_q[c] <= 32'h0000_0000;
        end else if (wr && is_ch && creg == CH_DATA && ok) begin
            data_q[ch] <= merge(data_q[ch], wb_i.dat, wb_i.sel);
        end
    end

    // Pending word per structure: notify in [15:0], release in [31:16]
    generate
        for (genvar s = 0; s < NUM_STR; s++) begin : g_str
            logic [31:0] set_w;
            logic [31:0] clr_w;
            always_comb begin
                set_w = 32'h0;
                if (do_nfy && wb_i.dat[s]) set_w[ch] = 1'b1;
                if (do_rel && wb_i.dat[s]) set_w[5'(16 + ch)] = 1'b1;
                clr_w = (wr && is_st && st == 4'(s) && !sreg) ? merge(32'h0, wb_i.dat, wb_i.sel) : 32'h0;
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    npend_q[s] <= 32'h0;
                    mask_q[s] <= 32'h0;
                    ipc_irq_o[s] <= 1'b0;
                end else begin
                    npend_q[s] <= (npend_q[s] & ~clr_w) | set_w;
                    if (wr && is_st && st == 4'(s) && sreg) mask_q[s] <= merge(mask_q[s], wb_i.dat, wb_i.sel);
                    ipc_irq_o[s] <= |(npend_q[s] & mask_q[s]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Routing and priority
    // ----------------------------------------------------------------
    logic [SEC_LINES-1:0] sec_line_d;
    logic [7:0] best_id;
    logic [2:0] best_p;
    logic found;
    logic [2:0] sbest;
    logic [1:0] sbest_p;
    logic sfound;

    always_comb begin
        sec_line_d = '0;
        for (int n = 0; n < NUM_SRC; n++) begin
            if (src_i[n] && ent_q[n].sec_en && ent_q[n].line != SYS_LINE) sec_line_d[ent_q[n].line] = 1'b1;
        end
        // Line 7 multiplexer carries the system structures instead
        sec_line_d[SYS_LINE] = |ipc_irq_o[SYS_STR-1:0];
    end

    // Lower value wins; ties go to the lower source number, or to the lower line number for the secondary core
    always_comb begin
        best_id = 8'h00;
        best_p = 3'h7;
        found = 1'b0;
        for (int n = 0; n < NUM_SRC; n++) begin
            if (src_i[n] && (!found || ent_q[n].prio < best_p)) begin
                best_id = 8'(n);
                best_p = ent_q[n].prio;
                found = 1'b1;
            end
        end
        sbest = 3'h0;
        sbest_p = 2'h3;
        sfound = 1'b0;
        for (int i = 0; i < SEC_LINES; i++) begin
            if (sec_line_d[i] && (!sfound || sec_prio_q[i*2+:2] < sbest_p)) begin
                sbest = 3'(i);
                sbest_p = sec_prio_q[i*2+:2];
                sfound = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_irq_o <= '0;
            sec_irq_o <= '0;
            main_nmi_o <= 1'b0;
            sec_nmi_o <= 1'b0;
            main_top_id_o <= 8'h00;
            main_top_prio_o <= 3'h0;
            main_top_valid_o <= 1'b0;
            sec_top_line_o <= 3'h0;
            sec_top_valid_o <= 1'b0;
        end else begin
            main_irq_o <= src_i;
            sec_irq_o <= sec_line_d;
            main_nmi_o <= nmi_hit(src_i, nmi_main_q);
            sec_nmi_o <= nmi_hit(src_i, nmi_sec_q) | (|sysreq_q);
            main_top_id_o <= best_id;
            main_top_prio_o <= best_p;
            main_top_valid_o <= found;
            sec_top_line_o <= sbest;
            sec_top_valid_o <= sfound;
        end
    end

    // ----------------------------------------------------------------
    // Wakeup units
    // ----------------------------------------------------------------
    dci_wake u_main_wake (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sleep_i(main_sleep_i),
        .src_i(|(src_i & wake_en)),
        .wake_o(main_wake_o)
    );

    // Secondary also wakes for a system function request
    dci_wake u_sec_wake (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sleep_i(sec_sleep_i),
        .src_i((|(src_i & wake_en)) | (|sysreq_q)),
        .wake_o(sec_wake_o)
    );

    // ----------------------------------------------------------------
    // Read path and acknowledge
    // ----------------------------------------------------------------
    logic [31:0] rdat;

    always_comb begin
        rdat = 32'h0;
        if (is_ch) begin
            if (ok) begin
                unique case (creg)
                    CH_ACQUIRE: rdat = {~lock_q[ch], lock_q[ch], 29'h0, owner_q[ch]};
                    CH_RELEASE: rdat = {lock_q[ch], 30'h0, owner_q[ch]};
                    CH_NOTIFY: rdat = 32'h0;
                    CH_DATA: rdat = data_q[ch];
                endcase
            end
        end else if (is_st) begin
            rdat = sreg ? mask_q[st] : npend_q[st];
        end else begin
            unique case (wb_i.adr)
                A_ENT_SEL: rdat = {24'h0, ent_sel_q};
                A_ENT_DATA: rdat = (ent_sel_q < 8'(NUM_SRC)) ? {23'h0, ent_q[ent_sel_q]} : 32'h0;
                A_NMI_MAIN: rdat = nmi_main_q;
                A_NMI_SEC: rdat = nmi_sec_q;
                A_SWINT: rdat = {24'h0, sec_swint_o};
                A_SYSREQ: rdat = {29'h0, sysreq_q};
                A_SEC_PRIO: rdat = {16'h0, sec_prio_q};
                A_STATUS: rdat = {16'h0, main_top_valid_o, 2'h0, main_top_prio_o, 2'h0, main_top_id_o};
                default: rdat = 32'h0;
            endcase
        end
    end

    // One wait state: ack follows the request by one edge and drops after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_o <= '0;
        end else begin
            ack_q <= acc;
            wb_o.ack <= acc;
            wb_o.dat <= rd ? rdat : 32'h0;
        end
    end
endmodule : dci_router

// file: dci_router_sva.sv
/*
 * Port checker for dci_router.
 * Assumes one clock domain and a synchronous active-high reset.
 */
module dci_router_sva
    import dci_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [dci_pkg::NUM_SRC-1:0] src_i,
    input wire dci_pkg::dci_wb_req_t wb_i,
    input wire dci_pkg::dci_wb_rsp_t wb_o,
    input wire logic main_sysreq_i,
    input wire logic main_sleep_i,
    input wire logic [dci_pkg::NUM_SRC-1:0] main_irq_o,
    input wire logic main_top_valid_o,
    input wire logic main_wake_o,
    input wire logic [dci_pkg::SW_INTS-1:0] sec_swint_o,
    input wire logic sec_nmi_o,
    input wire logic [dci_pkg::NUM_STR-1:0] ipc_irq_o
);
    import dci_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_w;
    assign wr_w = wb_i.cyc && wb_i.stb && wb_i.we;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_src_direct: assert property (!$past(rst_i) |-> main_irq_o == $past(src_i))
        else $error("main request lines differ from sources");
    a_ack_answer: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack held longer than one cycle");
    a_dat_idle: assert property (!wb_o.ack |-> wb_o.dat == '0)
        else $error("read data not zero outside ack");
    // Reset check must not be switched off by the reset itself
    a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_o.ack && !sec_nmi_o
        && main_irq_o == '0 && ipc_irq_o == '0 && sec_swint_o == '0)
        else $error("outputs not quiet in reset");
    a_sysreq_nmi: assert property (main_sysreq_i |-> ##[1:2] sec_nmi_o)
        else $error("system request did not raise secondary nmi");
    a_wake_sleep: assert property ($rose(main_wake_o) |-> $past(main_sleep_i))
        else $error("wake raised while core awake");
    a_wake_leave: assert property (main_wake_o && !main_sleep_i |=> !main_wake_o)
        else $error("wake held after sleep ended");
    a_ipc_cause: assert property ((ipc_irq_o & ~$past(ipc_irq_o)) != '0
        |-> $past(wr_w) || $past(wr_w, 2))
        else $error("inter-core interrupt rose without a write");
    a_top_cause: assert property ($rose(main_top_valid_o) |-> $past(|src_i))
        else $error("top pending valid without a source");

    c_read: cover property (wb_o.ack && !wb_i.we);
    c_nmi: cover property ($rose(sec_nmi_o));
    c_wake: cover property ($rose(main_wake_o));
    c_ipc: cover property (ipc_irq_o != '0);
endmodule : dci_router_sva

bind dci_router dci_router_sva u_dci_router_sva (
    .clk_i(clk_i), .rst_i(rst_i), .src_i(src_i), .wb_i(wb_i), .wb_o(wb_o),
    .main_sysreq_i(main_sysreq_i), .main_sleep_i(main_sleep_i), .main_irq_o(main_irq_o),
    .main_top_valid_o(main_top_valid_o), .main_wake_o(main_wake_o),
    .sec_swint_o(sec_swint_o), .sec_nmi_o(sec_nmi_o), .ipc_irq_o(ipc_irq_o)
);

// file: dci_sync.sv
/*
 * Three-stage synchroniser for a level from outside the clock domain.
 * The output changes only once the second and third stages agree.
 */
module dci_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end
endmodule : dci_sync

// file: dci_wake.sv
/*
 * Sleep wakeup unit for one core: while the core sleeps deeply, any
 * enabled wake source latches a wake request that holds until the core
 * leaves sleep. Assumes sleep_i is a same-clock level from the core.
 */
module dci_wake (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sleep_i,
    input wire logic src_i,
    output logic wake_o
);
    // Held so a brief source pulse is not lost before the core wakes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= sleep_i & (wake_o | src_i);
        end
    end
endmodule : dci_wake

// file: test_dci_router.sv
/*
 * Self-checking bench for dci_router: Wishbone tasks, source drive
 * and the core model. Assumes a 125 MHz clock.
 */
module test_dci_router;
    timeunit 1ns;
    timeprecision 1ps;
    import dci_pkg::*;
    logic clk_i;
    logic rst_i;
    logic [NUM_SRC-1:0] src_q;
    dci_wb_req_t wb_q;
    dci_wb_rsp_t wb_o;
    logic [2:0] req_w;
    logic [1:0] slp_w;
    logic [NUM_SRC-1:0] main_irq_o;
    logic main_nmi_o;
    logic [7:0] main_top_id_o;
    logic [2:0] main_top_prio_o;
    logic main_top_valid_o;
    logic main_wake_o;
    logic [7:0] sec_irq_o;
    logic [7:0] sec_swint_o;
    logic sec_nmi_o;
    logic [2:0] sec_top_line_o;
    logic sec_top_valid_o;
    logic sec_wake_o;
    logic [15:0] ipc_irq_o;
    logic [31:0] rd;
    int errors;
    int checks;

    dci_router u_dci_router (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_q), .wb_i(wb_q), .wb_o(wb_o),
        .main_sysreq_i(req_w[0]), .sec_sysreq_i(req_w[1]), .dap_sysreq_i(req_w[2]),
        .main_sleep_i(slp_w[0]), .sec_sleep_i(slp_w[1]), .main_irq_o(main_irq_o),
        .main_nmi_o(main_nmi_o), .main_top_id_o(main_top_id_o), .main_top_prio_o(main_top_prio_o),
        .main_top_valid_o(main_top_valid_o), .main_wake_o(main_wake_o), .sec_irq_o(sec_irq_o),
        .sec_swint_o(sec_swint_o), .sec_nmi_o(sec_nmi_o), .sec_top_line_o(sec_top_line_o),
        .sec_top_valid_o(sec_top_valid_o), .sec_wake_o(sec_wake_o), .ipc_irq_o(ipc_irq_o));
    dci_core_model u_dci_core_model (.clk_i(clk_i), .sysreq_o(req_w), .sleep_o(slp_w));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic bus(input logic c, input logic w, input logic [11:0] a, input logic [31:0] d);
        wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d, core: c};
        @(posedge clk_i);
        while (wb_o.ack !== 1'b1) @(posedge clk_i);
        rd = wb_o.dat;
        wb_q <= '0;
        @(posedge clk_i);
    endtask : bus
    task automatic rchk(input logic c, input logic [11:0] a, input logic [31:0] exp);
        bus(c, 1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic ent(input logic [7:0] s, input logic [8:0] v);
        bus(1'b0, 1'b1, A_ENT_SEL, {24'h0, s});
        bus(1'b0, 1'b1, A_ENT_DATA, {23'h0, v});
    endtask : ent
    task automatic setsrc(input int a, input int b);
        logic [NUM_SRC-1:0] v;
        v = '0;
        if (a >= 0) v[a] = 1'b1;
        if (b >= 0) v[b] = 1'b1;
        src_q <= v;
        tick(3);
    endtask : setsrc
    task automatic finish_test;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        errors++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        src_q = '0;
        wb_q = '0;
        errors = 0;
        checks = 0;
        tick(12);
        rst_i <= 1'b0;
        tick(1);
        chk({|main_irq_o, |sec_irq_o, main_top_valid_o, sec_top_valid_o, main_nmi_o, sec_nmi_o,
            main_wake_o, sec_wake_o, sec_swint_o, ipc_irq_o}, 32'h0);
        rchk(1'b0, A_ENT_DATA, 32'h0000_0007);
        rchk(1'b0, A_NMI_MAIN, 32'hFFFF_FFFF);
        rchk(1'b0, A_SEC_PRIO, 32'h0000_FFFF);
        rchk(1'b0, 12'h0FC, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            setsrc(i * 87, -1);
            chk(main_irq_o === src_q, 1'b1);
        end
        ent(8'h07, 9'h001);
        setsrc(3, 7);
        chk({main_top_valid_o, main_top_prio_o, main_top_id_o}, 12'h907);
        rchk(1'b0, A_STATUS, 32'h0000_8407);
        setsrc(3, -1);
        chk({main_top_valid_o, main_top_prio_o, main_top_id_o}, 12'hF03);
        $display("test priority done");
        ent(8'h03, 9'h0A7);
        ent(8'h32, 9'h0A7);
        ent(8'h3C, 9'h0F7);
        setsrc(50, -1);
        chk(sec_irq_o, 8'h04);
        chk({sec_top_valid_o, sec_top_line_o}, 4'hA);
        setsrc(3, 50);
        chk(sec_irq_o, 8'h04);
        setsrc(60, -1);
        chk(sec_irq_o, 8'h00);
        bus(1'b1, 1'b1, A_SWINT, 32'h0000_00A5);
        chk(sec_swint_o, 8'hA5);
        bus(1'b0, 1'b1, A_NMI_MAIN, 32'h0D0C_0B0A);
        for (int i = 10; i < 15; i++) begin
            setsrc(i, -1);
            chk(main_nmi_o, i < 14);
        end
        bus(1'b0, 1'b1, A_NMI_SEC, 32'h0);
        rchk(1'b0, A_NMI_SEC, 32'hFFFF_FFFF);
        $display("test routing done");
        for (int i = 0; i < 3; i++) begin
            u_dci_core_model.sysreq(i);
            tick(8);
            chk(sec_nmi_o, 1'b1);
            rchk(1'b1, A_SYSREQ, 32'h1 << i);
            bus(1'b1, 1'b1, A_SYSREQ, 32'h1 << i);
            tick(2);
            chk(sec_nmi_o, 1'b0);
        end
        ent(8'h2C, 9'h107);
        ent(8'h2D, 9'h107);
        u_dci_core_model.sleep(1'b1, 1'b0);
        setsrc(45, -1);
        chk(main_wake_o, 1'b0);
        setsrc(44, -1);
        setsrc(-1, -1);
        chk(main_wake_o, 1'b1);
        u_dci_core_model.sleep(1'b0, 1'b1);
        tick(2);
        chk(main_wake_o, 1'b0);
        setsrc(44, -1);
        chk(sec_wake_o, 1'b1);
        u_dci_core_model.sleep(1'b0, 1'b0);
        $display("test wake done");
        bus(1'b0, 1'b1, 12'h24C, 32'h0100_0100);
        rchk(1'b0, 12'h180, 32'h8000_0000);
        rchk(1'b1, 12'h180, 32'h4000_0000);
        bus(1'b1, 1'b1, 12'h184, 32'h0000_0200);
        chk(ipc_irq_o, 16'h0000);
        rchk(1'b1, 12'h184, 32'h8000_0000);
        bus(1'b0, 1'b1, 12'h184, 32'h0000_0200);
        tick(1);
        chk(ipc_irq_o, 16'h0200);
        rchk(1'b0, 12'h184, 32'h0);
        rchk(1'b0, 12'h248, 32'h0100_0000);
        bus(1'b0, 1'b1, 12'h248, 32'h0100_0000);
        bus(1'b0, 1'b1, 12'h188, 32'h0000_0200);
        rchk(1'b0, 12'h248, 32'h0000_0100);
        bus(1'b0, 1'b1, 12'h248, 32'h0000_0100);
        tick(1);
        chk(ipc_irq_o, 16'h0000);
        rchk(1'b0, 12'h100, 32'h0);
        rchk(1'b1, 12'h100, 32'h8000_0000);
        rchk(1'b0, 12'h1F0, 32'h8000_0000);
        bus(1'b1, 1'b1, 12'h10C, 32'h1234_5678);
        bus(1'b0, 1'b1, 12'h10C, 32'h0);
        rchk(1'b1, 12'h10C, 32'h1234_5678);
        $display("test channels done");
        finish_test();
    end
endmodule : test_dci_router
